/* File: cvps_pkg.sv */
package cvps_pkg;
  // ====================================================
  // register map (byte addresses, one word each)
  localparam logic [7:0] ADDR_CTRL0 = 8'h00;
  localparam logic [7:0] ADDR_LSCTL = 8'h04;
  localparam logic [7:0] ADDR_HSCTL = 8'h08;
  localparam logic [7:0] ADDR_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_DEEP = 8'h10;
  localparam logic [7:0] ADDR_RSTIV = 8'h14;
  localparam logic [7:0] ADDR_STAT = 8'h18;
  // ====================================================
  // key and field positions
  localparam logic [7:0] KEY_OPEN = 8'ha5;
  localparam logic [7:0] KEY_LOCK = 8'h00;
  localparam int CTRL_KEY_LSB = 8;
  localparam int CTRL_SWBOR = 2;
  localparam int CTRL_SWPOR = 3;
  localparam int CTRL_REGOFF = 4;
  localparam int FLG_SETTLE = 0;
  localparam int FLG_REACHED = 1;
  localparam int FLG_LOWMON = 2;
  localparam int FLG_BOR = 3;
  localparam int FLG_POR = 4;
  localparam int LS_SVS_FP = 6;
  localparam int LS_SVM_FP = 7;
  localparam int LS_MD = 8;
  localparam int LS_ACE = 9;
  localparam int HS_SVS_FP = 6;
  localparam int HS_SVM_FP = 7;
  localparam int HS_MD = 8;
  localparam int HS_ACE = 9;
  // ====================================================
  // reset values: lowest levels everywhere
  localparam logic [1:0] CORE_LVL_RST = 2'h0;
  localparam logic [5:0] THR_RST = 6'h00;
  localparam logic [3:0] RSTIV_NONE = 4'h0;
  localparam logic [3:0] RSTIV_BOR = 4'h2;
  localparam logic [3:0] RSTIV_POR = 4'h4;
  // ====================================================
  // timing
  localparam int CLK_MHZ = 100;
  localparam int SETTLE_US = 2;
  localparam int SETTLE_CYC = SETTLE_US * CLK_MHZ;
  localparam int LDO_HOLD_US = 5;
  localparam int LDO_HOLD_CYC = LDO_HOLD_US * CLK_MHZ;
  localparam logic [2:0] EXIT_EVERY_N = 3'h7;
  // ====================================================
  typedef enum logic [2:0] {CVPS_AM, CVPS_LPM01, CVPS_LPM2, CVPS_LPM3, CVPS_LPM4,
    CVPS_LPM35, CVPS_LPM45} cvps_mode_t;
  typedef struct packed {
    logic svs_on;
    logic svs_full;
    logic svm_on;
    logic svm_full;
  } cvps_perf_t;
endpackage

/* File: cvps_top.sv */
// Design decisions made here: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
// Summary of operation
// - reset returns core level, thresholds lowest
// - flag set when core reaches programmed level
// - key byte opens and locks writes
// - every eighth LPM3 or LPM4 exit holds regulator on
// - regulator_off disables core regulator deep
// - deep entry sets pin hold lock
// - only pin condition kept while held
// - sw brownout trigger resets, sets flag
// - sw poweron trigger resets, sets flag
// - event flags clear by write, brownout and poweron flags also by vector read
// - triggers self clear, read zero
// - brownout holds reset until supply good
// - manual mode uses own fullperf bit
// - supervisors off in deepest sleep modes
// - automatic mode follows operating mode
// - low side control mode decoding
// - wake latency from low side only
// - refuse sleep while modules need resources
// - mask low events until settled, flag
module cvps_top (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic WB_WE_I,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic CORE_ABOVE_LS_MON,
  input wire logic CORE_BELOW_LS_MON,
  input wire logic SUPPLY_GOOD,
  input wire logic SLEEP_REQ,
  input wire logic [2:0] SLEEP_MODE_REQ,
  input wire logic MODULE_HOLD_REQ,
  input wire logic WAKE_EVENT,
  input wire logic [15:0] PIN_STATE_IN,
  output logic [15:0] PIN_STATE_OUT,
  output logic PIN_HOLD,
  output logic PORT_CFG_CLEAR,
  output logic [1:0] CORE_LEVEL,
  output logic REGULATOR_EN,
  output logic BROWNOUT_RESET,
  output logic POWERON_RESET,
  output logic POWERUP_CLEAR,
  output logic [3:0] LS_PERF,
  output logic [3:0] HS_PERF,
  output logic WAKE_FAST,
  output logic [2:0] MODE_NOW
);
  // ====================================================
  // synchronisers for pin inputs
  // same two-flop delay on every pin, so request and mode code arrive together
  logic above, below, good, sleep_req, mod_hold, wake;
  logic [2:0] mode_req;
  cvps_sync #(.WIDTH(1)) cvps_sync_above_inst (
    .clk(CLK),
    .d(CORE_ABOVE_LS_MON),
    .q_reg(above)
  );
  cvps_sync #(.WIDTH(1)) cvps_sync_below_inst (
    .clk(CLK),
    .d(CORE_BELOW_LS_MON),
    .q_reg(below)
  );
  cvps_sync #(.WIDTH(1)) cvps_sync_good_inst (
    .clk(CLK),
    .d(SUPPLY_GOOD),
    .q_reg(good)
  );
  cvps_sync #(.WIDTH(1)) cvps_sync_req_inst (
    .clk(CLK),
    .d(SLEEP_REQ),
    .q_reg(sleep_req)
  );
  cvps_sync #(.WIDTH(1)) cvps_sync_hold_inst (
    .clk(CLK),
    .d(MODULE_HOLD_REQ),
    .q_reg(mod_hold)
  );
  cvps_sync #(.WIDTH(1)) cvps_sync_wake_inst (
    .clk(CLK),
    .d(WAKE_EVENT),
    .q_reg(wake)
  );
  cvps_sync #(.WIDTH(3)) cvps_sync_mode_inst (
    .clk(CLK),
    .d(SLEEP_MODE_REQ),
    .q_reg(mode_req)
  );
  // ====================================================
  // bus decode
  logic ack_reg;
  logic key_open_reg;
  logic [1:0] core_lvl_reg;
  logic [9:0] ls_ctl_reg, hs_ctl_reg;
  logic regoff_reg, lock_reg;
  logic settle_flag_reg, reached_flag_reg, lowmon_flag_reg, bor_flag_reg, por_flag_reg;
  logic [3:0] rstiv_reg;
  logic [8:0] settle_cnt_reg;
  logic [2:0] exit_cnt_reg;
  logic [8:0] ldo_cnt_reg;
  cvps_pkg::cvps_mode_t mode_reg;
  wire req = WB_CYC_I & WB_STB_I & ~ack_reg;
  wire wr = req & WB_WE_I;
  wire rd = req & ~WB_WE_I;
  wire sel_ctrl = WB_ADR_I == cvps_pkg::ADDR_CTRL0;
  wire sel_ls = WB_ADR_I == cvps_pkg::ADDR_LSCTL;
  wire sel_hs = WB_ADR_I == cvps_pkg::ADDR_HSCTL;
  wire sel_flg = WB_ADR_I == cvps_pkg::ADDR_FLAGS;
  wire sel_deep = WB_ADR_I == cvps_pkg::ADDR_DEEP;
  wire sel_iv = WB_ADR_I == cvps_pkg::ADDR_RSTIV;
  wire sel_st = WB_ADR_I == cvps_pkg::ADDR_STAT;
  wire key_wr = wr & sel_ctrl & WB_SEL_I[1];
  wire [7:0] key_byte = WB_DAT_I[15:8];
  wire wr_ok = wr & key_open_reg;
  wire ctrl_wr = wr_ok & sel_ctrl & WB_SEL_I[0];
  wire ls_wr = wr_ok & sel_ls & (WB_SEL_I[1:0] == 2'h3);
  wire hs_wr = wr_ok & sel_hs & (WB_SEL_I[1:0] == 2'h3);
  wire flg_wr = wr_ok & sel_flg & WB_SEL_I[0];
  wire deep_wr = wr_ok & sel_deep & WB_SEL_I[0];
  wire sw_bor = ctrl_wr & WB_DAT_I[cvps_pkg::CTRL_SWBOR];
  wire sw_por = ctrl_wr & WB_DAT_I[cvps_pkg::CTRL_SWPOR];
  wire bor_src = sw_bor | ~good;
  wire por_src = bor_src | sw_por;
  // ====================================================
  // operating mode and sleep entry
  wire deep_req = (mode_req == 3'h5) | (mode_req == 3'h6);
  // refuse sleep under module demand
  // code 7 names no mode and must not reach the state register
  wire enter_ok = sleep_req & ~mod_hold & (mode_req != 3'h0) & (mode_req != 3'h7);
  wire in_deep = (mode_reg == cvps_pkg::CVPS_LPM35) | (mode_reg == cvps_pkg::CVPS_LPM45);
  wire in_low = (mode_reg == cvps_pkg::CVPS_LPM2) | (mode_reg == cvps_pkg::CVPS_LPM3)
    | (mode_reg == cvps_pkg::CVPS_LPM4);
  wire in_l34 = (mode_reg == cvps_pkg::CVPS_LPM3) | (mode_reg == cvps_pkg::CVPS_LPM4);
  wire exit_l34 = in_l34 & wake;
  wire deep_ok = ~deep_req | regoff_reg;
  cvps_pkg::cvps_mode_t mode_next;
  always_comb
  begin
    mode_next = mode_reg;
    if (wake & (mode_reg != cvps_pkg::CVPS_AM))
      mode_next = cvps_pkg::CVPS_AM;
    else if ((mode_reg == cvps_pkg::CVPS_AM) & enter_ok & deep_ok)
      mode_next = cvps_pkg::cvps_mode_t'(mode_req);
  end
  // ====================================================
  // performance control
  // low and high side control decoding
  wire ls_svs_auto = ls_ctl_reg[cvps_pkg::LS_ACE] | ~ls_ctl_reg[cvps_pkg::LS_MD];
  wire ls_svm_auto = ls_ctl_reg[cvps_pkg::LS_ACE];
  wire hs_svs_auto = hs_ctl_reg[cvps_pkg::HS_ACE] | ~hs_ctl_reg[cvps_pkg::HS_MD];
  wire hs_svm_auto = hs_ctl_reg[cvps_pkg::HS_ACE];
  logic [1:0] ls_svs_p, ls_svm_p, hs_svs_p, hs_svm_p;
  cvps_perf_sel cvps_perf_ls_svs_inst (
    .auto_mode(ls_svs_auto),
    .full_bit(ls_ctl_reg[cvps_pkg::LS_SVS_FP]),
    .sleep_keep(ls_ctl_reg[cvps_pkg::LS_MD]),
    .in_low(in_low),
    .in_deep(in_deep),
    .perf(ls_svs_p)
  );
  cvps_perf_sel cvps_perf_ls_svm_inst (
    .auto_mode(ls_svm_auto),
    .full_bit(ls_ctl_reg[cvps_pkg::LS_SVM_FP]),
    .sleep_keep(1'b1),
    .in_low(in_low),
    .in_deep(in_deep),
    .perf(ls_svm_p)
  );
  cvps_perf_sel cvps_perf_hs_svs_inst (
    .auto_mode(hs_svs_auto),
    .full_bit(hs_ctl_reg[cvps_pkg::HS_SVS_FP]),
    .sleep_keep(hs_ctl_reg[cvps_pkg::HS_MD]),
    .in_low(in_low),
    .in_deep(in_deep),
    .perf(hs_svs_p)
  );
  cvps_perf_sel cvps_perf_hs_svm_inst (
    .auto_mode(hs_svm_auto),
    .full_bit(hs_ctl_reg[cvps_pkg::HS_SVM_FP]),
    .sleep_keep(1'b1),
    .in_low(in_low),
    .in_deep(in_deep),
    .perf(hs_svm_p)
  );
  wire fast_next = ~(ls_svs_p == 2'h2) & ~(ls_svm_p == 2'h2);
  // ====================================================
  // settle timer and flags
  // low side control change restarts settle delay
  wire ls_change = ls_wr & (WB_DAT_I[9:0] != ls_ctl_reg);
  wire settling = settle_cnt_reg != 9'h000;
  wire settle_done = settle_cnt_reg == 9'h001;
  wire reached_set = above & ~settling & ~in_deep;
  wire lowmon_set = below & ~settling & ~in_deep;
  wire iv_rd = rd & sel_iv;
  wire [4:0] flg_clr = flg_wr ? ~WB_DAT_I[4:0] : 5'h00;
  wire ldo_hold_start = exit_l34 & (exit_cnt_reg == cvps_pkg::EXIT_EVERY_N);
  wire [31:0] rdata_next =
    sel_ctrl ? {16'h0000, 3'h0, key_open_reg, 7'h00, regoff_reg, 2'h0, core_lvl_reg} :
    sel_ls ? {22'h0, ls_ctl_reg} :
    sel_hs ? {22'h0, hs_ctl_reg} :
    sel_flg ? {27'h0, por_flag_reg, bor_flag_reg, lowmon_flag_reg, reached_flag_reg,
      settle_flag_reg} :
    sel_deep ? {31'h0, lock_reg} :
    sel_iv ? {28'h0, rstiv_reg} :
    sel_st ? {23'h0, settling, REGULATOR_EN, mode_reg, ls_svs_p, ls_svm_p} : 32'h0;
  // ====================================================
  // registers
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      ack_reg <= 1'b0;
      key_open_reg <= 1'b0;
      mode_reg <= cvps_pkg::CVPS_AM;
      settle_cnt_reg <= 9'h000;
      exit_cnt_reg <= 3'h0;
      ldo_cnt_reg <= 9'h000;
      lock_reg <= 1'b0;
      regoff_reg <= 1'b0;
      {settle_flag_reg, reached_flag_reg, lowmon_flag_reg} <= 3'h0;
      {bor_flag_reg, por_flag_reg} <= 2'h0;
      rstiv_reg <= cvps_pkg::RSTIV_NONE;
      core_lvl_reg <= cvps_pkg::CORE_LVL_RST;
      ls_ctl_reg <= {4'h0, cvps_pkg::THR_RST};
      hs_ctl_reg <= {4'h0, cvps_pkg::THR_RST};
    end
    else
    begin
      ack_reg <= req;
      if (key_wr)
        key_open_reg <= key_byte == cvps_pkg::KEY_OPEN;
      mode_reg <= mode_next;
      if (ctrl_wr)
      begin
        core_lvl_reg <= WB_DAT_I[1:0];
        regoff_reg <= WB_DAT_I[cvps_pkg::CTRL_REGOFF];
      end
      if (ls_wr)
        ls_ctl_reg <= WB_DAT_I[9:0];
      if (hs_wr)
        hs_ctl_reg <= WB_DAT_I[9:0];
      if (ls_change)
        settle_cnt_reg <= 9'(cvps_pkg::SETTLE_CYC);
      else if (settling)
        settle_cnt_reg <= settle_cnt_reg - 9'h001;
      // set beats clear for every flag
      settle_flag_reg <= settle_done | (settle_flag_reg & ~flg_clr[cvps_pkg::FLG_SETTLE]);
      reached_flag_reg <= reached_set | (reached_flag_reg & ~flg_clr[cvps_pkg::FLG_REACHED]);
      lowmon_flag_reg <= lowmon_set | (lowmon_flag_reg & ~flg_clr[cvps_pkg::FLG_LOWMON]);
      bor_flag_reg <= bor_src | (bor_flag_reg & ~flg_clr[cvps_pkg::FLG_BOR] & ~iv_rd);
      por_flag_reg <= por_src | (por_flag_reg & ~flg_clr[cvps_pkg::FLG_POR] & ~iv_rd);
      if (bor_src)
        rstiv_reg <= cvps_pkg::RSTIV_BOR;
      else if (sw_por)
        rstiv_reg <= cvps_pkg::RSTIV_POR;
      else if (iv_rd)
        rstiv_reg <= cvps_pkg::RSTIV_NONE;
      if (exit_l34)
        exit_cnt_reg <= exit_cnt_reg + 3'h1;
      if (ldo_hold_start)
        ldo_cnt_reg <= 9'(cvps_pkg::LDO_HOLD_CYC);
      else if (ldo_cnt_reg != 9'h000)
        ldo_cnt_reg <= ldo_cnt_reg - 9'h001;
      if ((mode_next == cvps_pkg::CVPS_LPM35) | (mode_next == cvps_pkg::CVPS_LPM45))
        lock_reg <= 1'b1;
      else if (deep_wr & ~WB_DAT_I[0])
        lock_reg <= 1'b0;
    end
  end
  // ====================================================
  // outputs, all registered
  always_ff @(posedge CLK)
  begin
    if (SYS_RST)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
      PIN_STATE_OUT <= 16'h0000;
      PIN_HOLD <= 1'b0;
      PORT_CFG_CLEAR <= 1'b0;
      CORE_LEVEL <= cvps_pkg::CORE_LVL_RST;
      REGULATOR_EN <= 1'b1;
      BROWNOUT_RESET <= 1'b0;
      POWERON_RESET <= 1'b0;
      POWERUP_CLEAR <= 1'b0;
      LS_PERF <= 4'h0;
      HS_PERF <= 4'h0;
      WAKE_FAST <= 1'b1;
      MODE_NOW <= 3'h0;
    end
    else
    begin
      WB_ACK_O <= req;
      WB_DAT_O <= rd ? rdata_next : 32'h0;
      if (~lock_reg)
        PIN_STATE_OUT <= PIN_STATE_IN;
      PIN_HOLD <= lock_reg;
      PORT_CFG_CLEAR <= in_deep;
      CORE_LEVEL <= core_lvl_reg;
      REGULATOR_EN <= ~(in_deep & regoff_reg) | (ldo_cnt_reg != 9'h000) | ldo_hold_start;
      BROWNOUT_RESET <= bor_src;
      POWERON_RESET <= por_src;
      POWERUP_CLEAR <= por_src;
      LS_PERF <= {ls_svs_p, ls_svm_p};
      HS_PERF <= {hs_svs_p, hs_svm_p};
      WAKE_FAST <= fast_next;
      MODE_NOW <= mode_reg;
    end
  end
endmodule

// ====================================================
// two-flop synchroniser
// no reset: the chain flushes while reset is held
module cvps_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q_reg
);
  logic [WIDTH-1:0] meta_reg;
  always_ff @(posedge clk)
  begin
    meta_reg <= d;
    q_reg <= meta_reg;
  end
endmodule

// ====================================================
// performance selection of one supervisor or monitor
module cvps_perf_sel (
  input wire logic auto_mode,
  input wire logic full_bit,
  input wire logic sleep_keep,
  input wire logic in_low,
  input wire logic in_deep,
  output logic [1:0] perf
);
  wire keep_on = ~auto_mode | ~in_low;
  wire [1:0] auto_low = {full_bit & sleep_keep, 1'b0};
  wire [1:0] awake_perf = {1'b1, full_bit};
  assign perf = in_deep ? 2'h0 : (keep_on ? awake_perf : auto_low);
endmodule

/* File: cvps_top_properties.sv */
`timescale 1ns/10ps
// ====================================================
// port level checks
module cvps_props (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic SUPPLY_GOOD,
  input wire logic MODULE_HOLD_REQ,
  input wire logic [15:0] PIN_STATE_OUT,
  input wire logic PIN_HOLD,
  input wire logic PORT_CFG_CLEAR,
  input wire logic [1:0] CORE_LEVEL,
  input wire logic REGULATOR_EN,
  input wire logic BROWNOUT_RESET,
  input wire logic [3:0] LS_PERF,
  input wire logic [3:0] HS_PERF,
  input wire logic [2:0] MODE_NOW
);
  wire logic deep = (MODE_NOW == cvps_pkg::CVPS_LPM35) || (MODE_NOW == cvps_pkg::CVPS_LPM45);
  default clocking dc @(posedge CLK);
  endclocking
  default disable iff (SYS_RST);
  a_ack_after_take: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("no ack one cycle after take");
  a_ack_one_cycle: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack stood longer than one cycle");
  a_dat_idle_zero: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data without ack");
  a_reset_lowest: assert property ($fell(SYS_RST) |-> CORE_LEVEL == cvps_pkg::CORE_LVL_RST
    && REGULATOR_EN && !PIN_HOLD && LS_PERF == 4'h0) else $error("bad values after reset");
  // outputs may trail the mode by one sample, so deep is seen twice
  a_deep_reg_off: assert property (deep && $past(deep) |-> !REGULATOR_EN && PORT_CFG_CLEAR)
    else $error("regulator on or port config kept in deep sleep");
  a_deep_perf_off: assert property (deep && $past(deep) |-> LS_PERF == 4'h0 && HS_PERF == 4'h0)
    else $error("supervisor active in deep sleep");
  a_deep_pin_lock: assert property (deep |-> ##[0:2] PIN_HOLD)
    else $error("pin lock not set on deep entry");
  a_pins_frozen: assert property (PIN_HOLD && $past(PIN_HOLD) |-> $stable(PIN_STATE_OUT))
    else $error("held pins changed");
  a_sleep_refused: assert property
    (MODULE_HOLD_REQ [*4] ##0 MODE_NOW == cvps_pkg::CVPS_AM |=> MODE_NOW == cvps_pkg::CVPS_AM)
    else $error("sleep entered while a module holds");
  a_brownout_held: assert property (!SUPPLY_GOOD [*4] |-> BROWNOUT_RESET)
    else $error("no brownout reset while supply low");
  cover property (deep && PIN_HOLD);
  cover property (BROWNOUT_RESET);
  cover property (WB_ACK_O && WB_DAT_O != 32'h0);
  cover property (MODULE_HOLD_REQ && MODE_NOW == cvps_pkg::CVPS_AM);
endmodule

bind cvps_top cvps_props cvps_props_inst (.CLK(CLK), .SYS_RST(SYS_RST), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .SUPPLY_GOOD(SUPPLY_GOOD),
  .MODULE_HOLD_REQ(MODULE_HOLD_REQ), .PIN_STATE_OUT(PIN_STATE_OUT), .PIN_HOLD(PIN_HOLD),
  .PORT_CFG_CLEAR(PORT_CFG_CLEAR), .CORE_LEVEL(CORE_LEVEL), .REGULATOR_EN(REGULATOR_EN),
  .BROWNOUT_RESET(BROWNOUT_RESET), .LS_PERF(LS_PERF), .HS_PERF(HS_PERF), .MODE_NOW(MODE_NOW));

/* File: tb_top.sv */
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] q, rdat;
  logic [3:0] sel = 4'h0;
  logic we = 1'b0, cyc = 1'b0, stb = 1'b0, above = 1'b0, below = 1'b0, sgood = 1'b1;
  logic sreq = 1'b0, hreq = 1'b0, wake = 1'b0, bor_seen = 1'b0, por_seen = 1'b0;
  logic [2:0] smode = 3'h0;
  logic [15:0] pin_in = 16'h0000;
  logic [15:0] pin_out;
  logic ack, hold, cfgclr, regen, bor, por, power_up_clear, wfast;
  logic [1:0] lvl;
  logic [3:0] lsp, hsp;
  logic [2:0] mode;
  int mismatches = 0;
  int checked = 0;
  int cycles = 0;
  cvps_top cvps_top_inst (.CLK(clk), .SYS_RST(rst), .WB_ADR_I(adr), .WB_DAT_I(dat),
    .WB_SEL_I(sel), .WB_WE_I(we), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_DAT_O(rdat),
    .WB_ACK_O(ack), .CORE_ABOVE_LS_MON(above), .CORE_BELOW_LS_MON(below), .SUPPLY_GOOD(sgood),
    .SLEEP_REQ(sreq), .SLEEP_MODE_REQ(smode), .MODULE_HOLD_REQ(hreq), .WAKE_EVENT(wake),
    .PIN_STATE_IN(pin_in), .PIN_STATE_OUT(pin_out), .PIN_HOLD(hold), .PORT_CFG_CLEAR(cfgclr),
    .CORE_LEVEL(lvl), .REGULATOR_EN(regen), .BROWNOUT_RESET(bor), .POWERON_RESET(por),
    .POWERUP_CLEAR(power_up_clear), .LS_PERF(lsp), .HS_PERF(hsp), .WAKE_FAST(wfast), .MODE_NOW(mode));
  always #5 clk = ~clk;
  // reset pulses are latched so a short pulse is not missed
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (bor) bor_seen <= 1'b1;
    if (por & power_up_clear) por_seen <= 1'b1;
    if (cycles == 20000)
    begin
      mismatches++;
      conclude();
    end
  end
  task automatic conclude();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s exp %h got %h", n, e, g);
    end
  endtask
  // ====================================================
  // classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic [7:0] a, input logic [31:0] d, input logic w, input logic [3:0] s);
    int n;
    @(posedge clk);
    adr <= a;
    dat <= d;
    we <= w;
    sel <= s;
    cyc <= 1'b1;
    stb <= 1'b1;
    n = 0;
    do @(posedge clk) n++; while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 20) mismatches++;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic sleep(input logic [2:0] m);
    sreq <= 1'b1;
    smode <= m;
    tick(8);
  endtask
  task automatic wake_up();
    sreq <= 1'b0;
    wake <= 1'b1;
    tick(8);
    wake <= 1'b0;
    tick(2);
  endtask
  // ====================================================
  // scenarios
  task automatic t_key();
    wb(cvps_pkg::ADDR_LSCTL, 32'h0, 1'b0, 4'hf);
    cmp("lsctl rst", 32'h0, q);
    wb(8'h40, 32'h0, 1'b0, 4'hf);
    cmp("unmapped", 32'h0, q);
    wb(cvps_pkg::ADDR_CTRL0, 32'h1, 1'b1, 4'h1);
    tick(2);
    cmp("lvl locked", 32'h0, 32'(lvl));
    wb(cvps_pkg::ADDR_CTRL0, 32'ha500, 1'b1, 4'h2);
    wb(cvps_pkg::ADDR_CTRL0, 32'ha501, 1'b1, 4'hf);
    wb(cvps_pkg::ADDR_CTRL0, 32'h0, 1'b0, 4'hf);
    cmp("key open", 32'h1001, q);
    wb(cvps_pkg::ADDR_CTRL0, 32'h0, 1'b1, 4'h2);
    wb(cvps_pkg::ADDR_CTRL0, 32'h2, 1'b1, 4'h1);
    wb(cvps_pkg::ADDR_CTRL0, 32'h0, 1'b0, 4'hf);
    cmp("relocked", 32'h1, q);
    wb(cvps_pkg::ADDR_CTRL0, 32'ha500, 1'b1, 4'h2);
  endtask
  task automatic t_raise();
    wb(cvps_pkg::ADDR_FLAGS, 32'h0, 1'b1, 4'hf);
    wb(cvps_pkg::ADDR_HSCTL, 32'h1, 1'b1, 4'hf);
    wb(cvps_pkg::ADDR_LSCTL, 32'h1, 1'b1, 4'hf);
    wb(cvps_pkg::ADDR_STAT, 32'h0, 1'b0, 4'hf);
    cmp("settling", 32'h100, q & 32'h100);
    wb(cvps_pkg::ADDR_FLAGS, 32'h0, 1'b0, 4'hf);
    cmp("settle early", 32'h0, q & 32'h1);
    tick(cvps_pkg::SETTLE_CYC + 10);
    wb(cvps_pkg::ADDR_FLAGS, 32'h0, 1'b0, 4'hf);
    cmp("settle done", 32'h1, q & 32'h1);
    wb(cvps_pkg::ADDR_FLAGS, 32'h0, 1'b1, 4'hf);
    wb(cvps_pkg::ADDR_CTRL0, 32'ha502, 1'b1, 4'hf);
    above <= 1'b1;
    tick(8);
    wb(cvps_pkg::ADDR_FLAGS, 32'h0, 1'b0, 4'hf);
    cmp("reached", 32'h2, q & 32'h2);
    above <= 1'b0;
    // lower one step: low side first, then the core level
    wb(cvps_pkg::ADDR_LSCTL, 32'h0, 1'b1, 4'hf);
    tick(cvps_pkg::SETTLE_CYC + 10);
    wb(cvps_pkg::ADDR_FLAGS, 32'h0, 1'b0, 4'hf);
    cmp("lower settle", 32'h1, q & 32'h1);
    wb(cvps_pkg::ADDR_CTRL0, 32'ha501, 1'b1, 4'hf);
    tick(2);
    cmp("lowered", 32'h1, 32'(lvl));
  endtask
  task automatic t_swrst();
    wb(cvps_pkg::ADDR_CTRL0, 32'ha506, 1'b1, 4'hf);
    tick(4);
    cmp("bor pulse", 32'h3, {30'h0, bor_seen, por_seen});
    wb(cvps_pkg::ADDR_CTRL0, 32'h0, 1'b0, 4'hf);
    cmp("trig zero", 32'h0, q & 32'hc);
    wb(cvps_pkg::ADDR_FLAGS, 32'h0, 1'b0, 4'hf);
    cmp("bor flag", 32'h8, q & 32'h8);
    wb(cvps_pkg::ADDR_RSTIV, 32'h0, 1'b0, 4'hf);
    cmp("vector", 32'h2, q & 32'hf);
    wb(cvps_pkg::ADDR_FLAGS, 32'h0, 1'b0, 4'hf);
    cmp("flags read clr", 32'h0, q & 32'h18);
    wb(cvps_pkg::ADDR_CTRL0, 32'ha500, 1'b1, 4'h2);
    por_seen <= 1'b0;
    wb(cvps_pkg::ADDR_CTRL0, 32'ha50a, 1'b1, 4'h3);
    tick(4);
    cmp("por pulse", 32'h1, 32'(por_seen));
    wb(cvps_pkg::ADDR_FLAGS, 32'h0, 1'b0, 4'hf);
    cmp("por flag", 32'h10, q & 32'h10);
    wb(cvps_pkg::ADDR_CTRL0, 32'ha500, 1'b1, 4'h2);
    wb(cvps_pkg::ADDR_FLAGS, 32'h0, 1'b1, 4'hf);
    wb(cvps_pkg::ADDR_FLAGS, 32'h0, 1'b0, 4'hf);
    cmp("flags write clr", 32'h0, q & 32'h10);
  endtask
  task automatic t_perf();
    wb(cvps_pkg::ADDR_LSCTL, 32'h100, 1'b1, 4'hf);
    wb(cvps_pkg::ADDR_HSCTL, 32'h0c1, 1'b1, 4'hf);
    tick(2);
    cmp("wake slow", 32'h0, 32'(wfast));
    cmp("hs manual", 32'hf, 32'(hsp));
    wb(cvps_pkg::ADDR_LSCTL, 32'h1c0, 1'b1, 4'hf);
    sleep(3'h3);
    cmp("manual lpm3", 32'hf, 32'(lsp));
    cmp("wake fast", 32'h1, 32'(wfast));
    cmp("hs auto lpm3", 32'h3, 32'(hsp));
    wake_up();
    wb(cvps_pkg::ADDR_LSCTL, 32'h2c0, 1'b1, 4'hf);
    sleep(3'h3);
    cmp("auto lpm3", 32'h2, 32'(lsp));
    wake_up();
    cmp("auto am", 32'hf, 32'(lsp));
    hreq <= 1'b1;
    sleep(3'h4);
    cmp("refused", 32'h0, 32'(mode));
    hreq <= 1'b0;
    tick(8);
    cmp("lpm4", 32'h4, 32'(mode));
    wake_up();
  endtask
  task automatic t_deep();
    pin_in <= 16'h5a5a;
    wb(cvps_pkg::ADDR_CTRL0, 32'h0, 1'b0, 4'hf);
    wb(cvps_pkg::ADDR_CTRL0, 32'ha510 | (q & 32'h3), 1'b1, 4'hf);
    sleep(3'h5);
    cmp("deep state", 32'h2b0, 32'({mode, regen, hold, cfgclr, lsp}));
    pin_in <= 16'h0ff0;
    tick(3);
    cmp("pins held", 32'h5a5a, 32'(pin_out));
    wake_up();
    wb(cvps_pkg::ADDR_CTRL0, 32'ha500, 1'b1, 4'h2);
    wb(cvps_pkg::ADDR_DEEP, 32'h0, 1'b0, 4'hf);
    cmp("lock bit", 32'h1, q & 32'h1);
    wb(cvps_pkg::ADDR_DEEP, 32'h0, 1'b1, 4'hf);
    tick(3);
    cmp("pins free", 32'h0ff0, 32'(pin_out));
    sgood <= 1'b0;
    tick(8);
    cmp("bor held", 32'h1, 32'(bor));
    sgood <= 1'b1;
    tick(10);
  endtask
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_key();
    t_raise();
    t_swrst();
    t_perf();
    t_deep();
    conclude();
  end
endmodule
